// file: ssr_status_flags.sv
// Purpose: serial receiver with idle, overrun, noise, framing, parity
//          and receiver-active flags behind a strobed register port
// Assumes: sample_tick_in is a one-cycle pulse at 16x the bit rate
// Notes:   flags clear by a status read that saw them, then a data read
`include "ssr_params.svh"

////////////////////////////////////////////////////////////////////////
// Contract
// - idle flag after full high character time
// - idle count starts after start bit
// - idle count option: count after stop
// - idle clears by status then data read
// - idle rearms only after new character
// - overrun sets, new character discarded
// - overrun clears by status then data read
// - seven/three samples, disagreement sets noise
// - noise clears by status then data read
// - zero stop bit sets framing error
// - framing clears by status then data read
// - wrong parity sets parity error flag
// - parity clears by status then data read
// - writes leave receiver-active flag alone
// - break length 10/11 or 13/14
// - framing detection ignores break select
// - active on start, cleared on idle
// - primary status bit positions fixed
// - full flag on transfer to data
// - nine-bit format keeps ninth bit
module ssr_status_flags (
  input  wire logic       clk_in,
  input  wire logic       rst_n_in,
  input  wire logic       rxd_in,
  input  wire logic       sample_tick_in,
  input  wire logic       nine_bit_in,
  input  wire logic       parity_check_enable_in,
  input  wire logic       parity_odd_in,
  input  wire logic       idle_count_after_stop_in,
  input  wire logic [1:0] addr_in,
  input  wire logic [7:0] wdata_in,
  input  wire logic       wr_in,
  input  wire logic       rd_in,
  output logic      [7:0] rdata_out,
  output logic            receive_full_out,
  output logic            receiver_active_out,
  output logic            long_break_select_out,
  output logic      [3:0] break_bits_out
);

  ssr_pkg::ssr_state_e state_r;
  ssr_pkg::ssr_flags_s flags_r;
  ssr_pkg::ssr_flags_s flags_nxt;
  ssr_pkg::ssr_flags_s arm_r;
  logic       rx_meta_r;
  logic       rx_sync_r;
  logic [3:0] ph_r;
  logic [2:0] ones_r;
  logic [3:0] bitcnt_r;
  logic [8:0] shift_r;
  logic       par_r;
  logic       noise_acc_r;
  logic [3:0] icnt_r;
  logic [3:0] icnt_nxt;
  logic       idle_arm_r;
  logic       full_r;
  logic       full_arm_r;
  logic       raf_r;
  logic       brk_sel_r;
  logic [3:0] brk_len_r;
  logic [7:0] data_r;
  logic       ninth_r;
  logic [7:0] rdata_r;
  logic       bit_end;
  logic       in_win;
  logic       bit_val;
  logic       bit_noise;
  logic       start_ok;
  logic       frame_done;
  logic       load;
  logic       ovr_ev;
  logic       idle_det;
  logic [3:0] idle_lim;
  logic [3:0] nbits;
  logic       rd_pri;
  logic       rd_data;

  ////////////////////////////////////////////////////////////////////////
  // two-flop synchroniser for the receive pin
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      rx_meta_r <= 1'b1;
      rx_sync_r <= 1'b1;
    end else begin
      rx_meta_r <= rxd_in;
      rx_sync_r <= rx_meta_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // bit timing decodes
  assign bit_end  = sample_tick_in && (ph_r == `SSR_PH_LAST);
  assign in_win   = (state_r == ssr_pkg::ssr_st_start)
                  ? (ph_r >= `SSR_PH_START_LO && ph_r <= `SSR_PH_MID_HI)
                  : (ph_r >= `SSR_PH_MID_LO && ph_r <= `SSR_PH_MID_HI);
  assign nbits    = nine_bit_in ? `SSR_DATA_BITS_9 : `SSR_DATA_BITS_8;
  assign idle_lim = nine_bit_in ? `SSR_IDLE_BITS_9 : `SSR_IDLE_BITS_8;

  assign start_ok  = (ones_r <= `SSR_START_MAX_ONES);
  assign bit_val   = (ones_r >= `SSR_BIT_MIN_ONES);
  assign bit_noise = (state_r == ssr_pkg::ssr_st_start)
                   ? (ones_r != 3'h0)
                   : (ones_r == 3'h1 || ones_r == 3'h2);

  assign frame_done = bit_end && (state_r == ssr_pkg::ssr_st_stop);
  assign load   = frame_done && !full_r;
  assign ovr_ev = frame_done && full_r;

  assign rd_pri  = rd_in && (addr_in == `SSR_ADDR_STATUS_PRI);
  assign rd_data = rd_in && (addr_in == `SSR_ADDR_DATA);

  ////////////////////////////////////////////////////////////////////////
  // sample phase: free-runs, restarts on a low line while idle
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      ph_r <= 4'h0;
    end else if (sample_tick_in) begin
      if (state_r == ssr_pkg::ssr_st_idle && !rx_sync_r) begin
        ph_r <= 4'h0;
      end else begin
        ph_r <= ph_r + 4'h1;
      end
    end
  end

  // count high samples in the bit window
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      ones_r <= 3'h0;
    end else if (state_r == ssr_pkg::ssr_st_idle || bit_end) begin
      ones_r <= 3'h0;
    end else if (sample_tick_in && in_win) begin
      ones_r <= ones_r + {2'h0, rx_sync_r};
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // receive sequencer
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      state_r  <= ssr_pkg::ssr_st_idle;
      bitcnt_r <= 4'h0;
    end else begin
      unique case (state_r)
        ssr_pkg::ssr_st_idle: begin
          if (sample_tick_in && !rx_sync_r) begin
            state_r <= ssr_pkg::ssr_st_start;
          end
        end
        ssr_pkg::ssr_st_start: begin
          if (bit_end) begin
            bitcnt_r <= 4'h0;
            state_r  <= start_ok ? ssr_pkg::ssr_st_data
                                 : ssr_pkg::ssr_st_idle;
          end
        end
        ssr_pkg::ssr_st_data: begin
          if (bit_end) begin
            bitcnt_r <= bitcnt_r + 4'h1;
            if (bitcnt_r == nbits - 4'h1) begin
              state_r <= ssr_pkg::ssr_st_stop;
            end
          end
        end
        ssr_pkg::ssr_st_stop: begin
          if (bit_end) begin
            state_r <= ssr_pkg::ssr_st_idle;
          end
        end
      endcase
    end
  end

  // shifter, running parity and noise accumulation
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      shift_r     <= 9'h000;
      par_r       <= 1'b0;
      noise_acc_r <= 1'b0;
    end else if (bit_end && state_r == ssr_pkg::ssr_st_start) begin
      par_r       <= 1'b0;
      noise_acc_r <= bit_noise;
    end else if (bit_end && state_r == ssr_pkg::ssr_st_data) begin
      shift_r     <= {bit_val, shift_r[8:1]};
      par_r       <= par_r ^ bit_val;
      noise_acc_r <= noise_acc_r | bit_noise;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // idle count includes data and stop bits
  // option holds the count at zero in frame
  always_comb begin
    icnt_nxt = icnt_r;
    if (state_r == ssr_pkg::ssr_st_idle) begin
      if (bit_end && rx_sync_r && icnt_r != `SSR_IDLE_CNT_SAT) begin
        icnt_nxt = icnt_r + 4'h1;
      end
    end else if (bit_end) begin
      if (state_r == ssr_pkg::ssr_st_start || idle_count_after_stop_in
          || !bit_val) begin
        icnt_nxt = 4'h0;
      end else begin
        icnt_nxt = icnt_r + 4'h1;
      end
    end
  end

  // one pulse when the count reaches a character
  assign idle_det = (icnt_nxt == idle_lim) && (icnt_r != idle_lim);

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      icnt_r <= `SSR_IDLE_CNT_SAT;
    end else begin
      icnt_r <= icnt_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // active from valid start until idle line
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      raf_r <= 1'b0;
    end else if (bit_end && state_r == ssr_pkg::ssr_st_start
                 && start_ok) begin
      raf_r <= 1'b1;
    end else if (idle_det) begin
      raf_r <= 1'b0;
    end
  end

  // idle flag armed by a new character
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      idle_arm_r <= 1'b0;
    end else if (load) begin
      idle_arm_r <= 1'b1;
    end else if (idle_det) begin
      idle_arm_r <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // status read records which set flags it saw
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      arm_r      <= `SSR_FLAGS_RST;
      full_arm_r <= 1'b0;
    end else if (rd_pri) begin
      arm_r      <= flags_r;
      full_arm_r <= full_r;
    end else if (rd_data) begin
      arm_r      <= `SSR_FLAGS_RST;
      full_arm_r <= 1'b0;
    end
  end

  // flag update: a set in the clearing cycle wins
  always_comb begin
    flags_nxt = flags_r;
    if (rd_data) begin
      flags_nxt = flags_r & ~arm_r;
    end
    if (load) begin
      flags_nxt.noise  = noise_acc_r | bit_noise;
      flags_nxt.frame  = !bit_val;
      flags_nxt.parity = parity_check_enable_in
                         && (par_r != parity_odd_in);
    end
    if (ovr_ev) begin
      flags_nxt.ovr = 1'b1;
    end
    if (idle_det && idle_arm_r) begin
      flags_nxt.idle = 1'b1;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      flags_r <= `SSR_FLAGS_RST;
    end else begin
      flags_r <= flags_nxt;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      full_r  <= 1'b0;
      data_r  <= `SSR_DATA_RST;
      ninth_r <= 1'b0;
    end else if (load) begin
      full_r  <= 1'b1;
      data_r  <= nine_bit_in ? shift_r[7:0] : shift_r[8:1];
      ninth_r <= nine_bit_in & shift_r[8];
    end else if (rd_data && full_arm_r) begin
      full_r  <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // only the break select is writable
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      brk_sel_r <= 1'b0;
    end else if (wr_in && addr_in == `SSR_ADDR_STATUS_SEC) begin
      brk_sel_r <= wdata_in[`SSR_SEC_BRK];
    end
  end

  // break length from select and format
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      brk_len_r <= `SSR_BRK_SHORT_8;
    end else if (brk_sel_r) begin
      brk_len_r <= nine_bit_in ? `SSR_BRK_LONG_9 : `SSR_BRK_LONG_8;
    end else begin
      brk_len_r <= nine_bit_in ? `SSR_BRK_SHORT_9 : `SSR_BRK_SHORT_8;
    end
  end

  // read data, valid the cycle after the strobe only
  always_ff @(posedge clk_in) begin
    if (!rst_n_in || !rd_in) begin
      rdata_r <= 8'h00;
    end else begin
      rdata_r <= 8'h00;
      unique case (addr_in)
        `SSR_ADDR_STATUS_PRI: begin
          rdata_r[`SSR_PRI_FULL]   <= full_r;
          rdata_r[`SSR_PRI_IDLE]   <= flags_r.idle;
          rdata_r[`SSR_PRI_OVR]    <= flags_r.ovr;
          rdata_r[`SSR_PRI_NOISE]  <= flags_r.noise;
          rdata_r[`SSR_PRI_FRAME]  <= flags_r.frame;
          rdata_r[`SSR_PRI_PARITY] <= flags_r.parity;
        end
        `SSR_ADDR_STATUS_SEC: begin
          rdata_r[`SSR_SEC_BRK]    <= brk_sel_r;
          rdata_r[`SSR_SEC_ACTIVE] <= raf_r;
        end
        `SSR_ADDR_NINTH: begin
          rdata_r[`SSR_NINTH_BIT]  <= ninth_r;
        end
        `SSR_ADDR_DATA: begin
          rdata_r <= data_r;
        end
      endcase
    end
  end

  assign rdata_out             = rdata_r;
  assign receive_full_out      = full_r;
  assign receiver_active_out   = raf_r;
  assign long_break_select_out = brk_sel_r;
  assign break_bits_out        = brk_len_r;

  ////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);

  a_noise_with_full: assert property (
    $rose(flags_r.noise) |-> $rose(full_r))
    else $error("noise flag rose without full flag");

  a_frame_with_full: assert property (
    frame_done && !full_r && !bit_val |=> flags_r.frame && full_r)
    else $error("zero stop bit did not set framing error");

  a_parity_with_full: assert property (
    $rose(flags_r.parity) |-> $rose(full_r) && parity_check_enable_in)
    else $error("parity flag rose without full flag or enable");

  a_ovr_keeps_data: assert property (
    ovr_ev && !rd_data
    |=> flags_r.ovr && $stable(data_r) && $stable(flags_r.frame))
    else $error("overrun did not keep old character");

  a_idle_needs_arm: assert property (
    $rose(flags_r.idle) |-> $past(idle_arm_r) && $past(idle_det))
    else $error("idle flag set without a new character");

  a_idle_after_char: assert property (
    $rose(flags_r.idle) |-> $past(icnt_r) == idle_lim - 4'h1)
    else $error("idle flag not at one character time");

  a_active_clear_idle: assert property (
    idle_det |=> !raf_r)
    else $error("active flag not cleared on idle line");

  a_data_read_alone: assert property (
    rd_data && arm_r == `SSR_FLAGS_RST && !full_arm_r
    |=> !$fell(flags_r.ovr) && !$fell(flags_r.idle) && !$fell(full_r))
    else $error("data read without status read cleared a flag");

  a_clear_sequence: assert property (
    rd_pri && flags_r.ovr ##1 (!rd_in && !wr_in)[*1] ##0 1'b1
    ##1 rd_data && !ovr_ev |=> !flags_r.ovr)
    else $error("status then data read did not clear overrun");

  a_write_no_active: assert property (
    wr_in && !bit_end |=> $stable(raf_r))
    else $error("write changed the active flag");

  a_read_status_bits: assert property (
    rd_pri |=> rdata_out[`SSR_PRI_OVR] == $past(flags_r.ovr)
            && rdata_out[`SSR_PRI_IDLE] == $past(flags_r.idle))
    else $error("primary status bits misplaced");

  a_break_length: assert property (
    1'b1 |=> break_bits_out == ($past(brk_sel_r)
      ? ($past(nine_bit_in) ? `SSR_BRK_LONG_9 : `SSR_BRK_LONG_8)
      : ($past(nine_bit_in) ? `SSR_BRK_SHORT_9 : `SSR_BRK_SHORT_8)))
    else $error("break length wrong");

endmodule : ssr_status_flags

// file: ssr_params.svh
// Purpose: constants of the serial receiver status-flag block
// Assumes: 25 MHz bus clock, 16 sample ticks per bit from the baud divider
// Notes:   definitions only, included by bare name
`ifndef SSR_PARAMS_SVH
`define SSR_PARAMS_SVH

////////////////////////////////////////////////////////////////////////
// register offsets (2-bit address)
`define SSR_ADDR_STATUS_PRI  2'h0
`define SSR_ADDR_STATUS_SEC  2'h1
`define SSR_ADDR_NINTH       2'h2
`define SSR_ADDR_DATA        2'h3

// primary status bit positions
`define SSR_PRI_FULL         5
`define SSR_PRI_IDLE         4
`define SSR_PRI_OVR          3
`define SSR_PRI_NOISE        2
`define SSR_PRI_FRAME        1
`define SSR_PRI_PARITY       0

// secondary status and ninth-bit positions
`define SSR_SEC_BRK          2
`define SSR_SEC_ACTIVE       0
`define SSR_NINTH_BIT        7

////////////////////////////////////////////////////////////////////////
// sample phases within one bit time
`define SSR_PH_LAST          4'hf
`define SSR_PH_START_LO      4'h3
`define SSR_PH_MID_LO        4'h7
`define SSR_PH_MID_HI        4'h9

// majority thresholds
`define SSR_START_MAX_ONES   3'h3
`define SSR_BIT_MIN_ONES     3'h2

// character and break lengths in bit times
`define SSR_DATA_BITS_8      4'h8
`define SSR_DATA_BITS_9      4'h9
`define SSR_IDLE_BITS_8      4'ha
`define SSR_IDLE_BITS_9      4'hb
`define SSR_BRK_SHORT_8      4'ha
`define SSR_BRK_SHORT_9      4'hb
`define SSR_BRK_LONG_8       4'hd
`define SSR_BRK_LONG_9       4'he
`define SSR_IDLE_CNT_SAT     4'hf

// reset values
`define SSR_FLAGS_RST        5'h00
`define SSR_DATA_RST         8'h00

`endif

// file: ssr_pkg.sv
// Purpose: types shared by the serial receiver status-flag block
// Assumes: nothing beyond the constants header
// Notes:   one-hot receive states, packed idle and error flags
package ssr_pkg;

  // receive sequencer states
  typedef enum logic [3:0] {
    ssr_st_idle  = 4'b0001,
    ssr_st_start = 4'b0010,
    ssr_st_data  = 4'b0100,
    ssr_st_stop  = 4'b1000
  } ssr_state_e;

  // sticky receive flags in primary status order
  typedef struct packed {
    logic idle;
    logic ovr;
    logic noise;
    logic frame;
    logic parity;
  } ssr_flags_s;

endpackage : ssr_pkg

// file: ssr_remote_tx.sv
// Purpose: remote serial transmitter driving the receive line
// Assumes: sample_tick_in pulses at 16x the bit rate
// Notes:   line idles high; can send bad stop bits and one-tick glitches
module ssr_remote_tx (
  input  wire logic clk_in,
  input  wire logic sample_tick_in,
  output logic      rxd_out
);
  timeunit 1ns;
  timeprecision 1ps;

  ////////////////////////////////////////////////////////////////////////
  // idle line level
  initial begin
    rxd_out = 1'b1;
  end

  // wait a number of sample ticks
  task automatic hold_ticks(input int n);
    repeat (n) @(posedge clk_in iff sample_tick_in);
  endtask : hold_ticks

  // one frame, lsb first; gl selects a data bit to glitch, -1 for none
  task automatic send(input logic [8:0] d, input int nb,
                      input logic stop_v, input int gl);
    logic [10:0] fr;
    fr = 11'h7ff;
    fr[0] = 1'b0;
    for (int i = 0; i < nb; i++) begin
      fr[i+1] = d[i];
    end
    fr[nb+1] = stop_v;
    for (int b = 0; b <= nb + 1; b++) begin
      rxd_out <= fr[b];
      // a negative bit index means a clean frame, start bit included
      if (gl >= 0 && b == gl + 1) begin
        hold_ticks(8);
        rxd_out <= ~fr[b];
        hold_ticks(1);
        rxd_out <= fr[b];
        hold_ticks(7);
      end else begin
        hold_ticks(16);
      end
    end
    rxd_out <= 1'b1; // released line goes back high
  endtask : send
endmodule : ssr_remote_tx

// file: test_ssr_status_flags.sv
// Purpose: self-checking bench for the receiver status-flag block
// Assumes: sample tick every second clock, so one bit time is 32 clocks
// Notes:   register tasks follow the strobed port with data a cycle later
`include "ssr_params.svh"

module test_ssr_status_flags;
  timeunit 1ns;
  timeprecision 1ps;

  localparam int BIT = 32; // clocks per bit time

  logic       clk_in;
  logic       rst_n_in;
  logic       rxd;
  logic       sample_tick_in = 1'b0;
  logic       nine_bit_in;
  logic       pe_in;
  logic       podd_in;
  logic       ilt_in;
  logic [1:0] addr_in;
  logic [7:0] wdata_in;
  logic       wr_in;
  logic       rd_in;
  logic [7:0] rdata_out;
  logic       full_out;
  logic       active_out;
  logic       lbrk_out;
  logic [3:0] brk_out;
  int         err_total;
  int         tests_run;
  int         cycles;

  ssr_status_flags i_ssr_status_flags (
    .clk_in                   (clk_in),
    .rst_n_in                 (rst_n_in),
    .rxd_in                   (rxd),
    .sample_tick_in           (sample_tick_in),
    .nine_bit_in              (nine_bit_in),
    .parity_check_enable_in   (pe_in),
    .parity_odd_in            (podd_in),
    .idle_count_after_stop_in (ilt_in),
    .addr_in                  (addr_in),
    .wdata_in                 (wdata_in),
    .wr_in                    (wr_in),
    .rd_in                    (rd_in),
    .rdata_out                (rdata_out),
    .receive_full_out         (full_out),
    .receiver_active_out      (active_out),
    .long_break_select_out    (lbrk_out),
    .break_bits_out           (brk_out)
  );

  ssr_remote_tx i_ssr_remote_tx (
    .clk_in         (clk_in),
    .sample_tick_in (sample_tick_in),
    .rxd_out        (rxd)
  );

  ////////////////////////////////////////////////////////////////////////
  // clock, sample tick and hang guard
  initial begin
    clk_in = 1'b0;
    forever #20 clk_in = ~clk_in;
  end

  always @(posedge clk_in) begin
    sample_tick_in <= ~sample_tick_in;
    cycles++;
    if (cycles == 40000) begin
      err_total++;
      tally_and_finish();
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // compare, report and register access
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : tally_and_finish

  task automatic test_end(input string name);
    $display("test %s done, mismatches %0d", name, err_total);
  endtask : test_end

  task automatic reg_wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge clk_in);
    wr_in    <= 1'b1;
    addr_in  <= a;
    wdata_in <= d;
    @(posedge clk_in);
    wr_in    <= 1'b0;
  endtask : reg_wr

  task automatic rd_chk(input logic [1:0] a, input logic [7:0] exp);
    @(posedge clk_in);
    rd_in   <= 1'b1;
    addr_in <= a;
    @(posedge clk_in);
    rd_in   <= 1'b0;
    #1;
    chk(rdata_out, exp);
  endtask : rd_chk

  task automatic wait_bits(input int n);
    repeat (n * BIT) @(posedge clk_in);
    #1;
  endtask : wait_bits

  // bounded wait for the receive-full level
  task automatic wait_full();
    int n;
    n = 0;
    while (full_out !== 1'b1 && n < 20 * BIT) begin
      @(posedge clk_in);
      #1;
      n++;
    end
    chk({7'h00, full_out}, 8'h01);
  endtask : wait_full

  // let the line go idle, then clear whatever is pending
  task automatic drain();
    wait_bits(13);
    @(posedge clk_in);
    rd_in   <= 1'b1;
    addr_in <= `SSR_ADDR_STATUS_PRI;
    @(posedge clk_in);
    addr_in <= `SSR_ADDR_DATA;
    @(posedge clk_in);
    rd_in   <= 1'b0;
  endtask : drain

  ////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    rst_n_in = 1'b0;
    nine_bit_in = 1'b0;
    pe_in = 1'b0;
    podd_in = 1'b0;
    ilt_in = 1'b0;
    addr_in = 2'h0;
    wdata_in = 8'h00;
    wr_in = 1'b0;
    rd_in = 1'b0;
    err_total = 0;
    tests_run = 0;
    repeat (6) @(posedge clk_in);
    rst_n_in <= 1'b1;

    // reset values, read-only places, break length
    rd_chk(`SSR_ADDR_STATUS_PRI, 8'h00);
    rd_chk(`SSR_ADDR_STATUS_SEC, 8'h00);
    reg_wr(`SSR_ADDR_STATUS_PRI, 8'hff);
    rd_chk(`SSR_ADDR_STATUS_PRI, 8'h00);
    chk({4'h0, brk_out}, 8'h0a);
    reg_wr(`SSR_ADDR_STATUS_SEC, 8'hff);
    rd_chk(`SSR_ADDR_STATUS_SEC, 8'h04);
    chk({6'h00, lbrk_out, active_out}, 8'h02);
    chk({4'h0, brk_out}, 8'h0d);
    @(posedge clk_in);
    nine_bit_in <= 1'b1;
    repeat (3) @(posedge clk_in);
    chk({4'h0, brk_out}, 8'h0e);
    reg_wr(`SSR_ADDR_STATUS_SEC, 8'h00);
    repeat (2) @(posedge clk_in);
    chk({4'h0, brk_out}, 8'h0b);
    nine_bit_in <= 1'b0;
    test_end("registers");

    // clean character, idle counted from after the start bit
    i_ssr_remote_tx.send(9'h0ff, 8, 1'b1, -1);
    wait_full();
    rd_chk(`SSR_ADDR_STATUS_PRI, 8'h20);
    chk({7'h00, active_out}, 8'h01);
    wait_bits(3);
    rd_chk(`SSR_ADDR_STATUS_PRI, 8'h30);
    chk({7'h00, active_out}, 8'h00);
    rd_chk(`SSR_ADDR_DATA, 8'hff);
    rd_chk(`SSR_ADDR_STATUS_PRI, 8'h00);
    wait_bits(12);
    rd_chk(`SSR_ADDR_STATUS_PRI, 8'h00);
    test_end("idle_after_start");

    // idle counted only after the stop bit
    @(posedge clk_in);
    ilt_in <= 1'b1;
    i_ssr_remote_tx.send(9'h0ff, 8, 1'b1, -1);
    wait_full();
    wait_bits(3);
    rd_chk(`SSR_ADDR_STATUS_PRI, 8'h20);
    wait_bits(9);
    rd_chk(`SSR_ADDR_STATUS_PRI, 8'h30);
    rd_chk(`SSR_ADDR_DATA, 8'hff);
    rd_chk(`SSR_ADDR_STATUS_PRI, 8'h00);
    @(posedge clk_in);
    ilt_in <= 1'b0;
    test_end("idle_after_stop");

    // framing error with long break selected, lone data read
    reg_wr(`SSR_ADDR_STATUS_SEC, 8'h04);
    i_ssr_remote_tx.send(9'h00f, 8, 1'b0, -1);
    wait_full();
    rd_chk(`SSR_ADDR_DATA, 8'h0f);
    rd_chk(`SSR_ADDR_STATUS_PRI, 8'h22);
    rd_chk(`SSR_ADDR_DATA, 8'h0f);
    rd_chk(`SSR_ADDR_STATUS_PRI, 8'h00);
    reg_wr(`SSR_ADDR_STATUS_SEC, 8'h00);
    drain();
    test_end("framing");

    // overrun drops the second character and its errors
    i_ssr_remote_tx.send(9'h011, 8, 1'b1, -1);
    wait_full();
    wait_bits(1);
    i_ssr_remote_tx.send(9'h022, 8, 1'b0, 2);
    repeat (16) @(posedge clk_in);
    rd_chk(`SSR_ADDR_STATUS_PRI, 8'h28);
    rd_chk(`SSR_ADDR_DATA, 8'h11);
    rd_chk(`SSR_ADDR_STATUS_PRI, 8'h00);
    drain();
    test_end("overrun");

    // noisy sample inside a data bit
    i_ssr_remote_tx.send(9'h05a, 8, 1'b1, 3);
    wait_full();
    rd_chk(`SSR_ADDR_STATUS_PRI, 8'h24);
    rd_chk(`SSR_ADDR_DATA, 8'h5a);
    rd_chk(`SSR_ADDR_STATUS_PRI, 8'h00);
    drain();
    test_end("noise");

    // parity sense and value table
    @(posedge clk_in);
    pe_in <= 1'b1;
    for (int o = 0; o < 2; o++) begin
      for (int k = 0; k < 2; k++) begin
        @(posedge clk_in);
        podd_in <= o[0];
        i_ssr_remote_tx.send(k ? 9'h083 : 9'h003, 8, 1'b1, -1);
        wait_full();
        rd_chk(`SSR_ADDR_STATUS_PRI, 8'h20 | {7'h00, k[0] ^ o[0]});
        rd_chk(`SSR_ADDR_DATA, k ? 8'h83 : 8'h03);
        rd_chk(`SSR_ADDR_STATUS_PRI, 8'h00);
      end
    end
    @(posedge clk_in);
    pe_in <= 1'b0;
    drain();
    test_end("parity");

    // nine data bits, ninth kept beside the byte
    @(posedge clk_in);
    nine_bit_in <= 1'b1;
    i_ssr_remote_tx.send(9'h1c3, 9, 1'b1, -1);
    wait_full();
    rd_chk(`SSR_ADDR_STATUS_PRI, 8'h20);
    rd_chk(`SSR_ADDR_NINTH, 8'h80);
    rd_chk(`SSR_ADDR_DATA, 8'hc3);
    drain();
    nine_bit_in <= 1'b0;
    test_end("nine_bit");

    tally_and_finish();
  end
endmodule : test_ssr_status_flags
